/* File: inc/ppc_cfg_if.sv */
// Purpose: Write port between the control core and the property store
// Assumes: One write per cycle at most
// Notes: Read side exposes all four property words
`timescale 1ns/10ps
`default_nettype none
interface ppc_cfg_if;
  logic wr_en;
  logic [1:0] wr_sel;
  ppc_pkg::ppc_word_t wr_data;
  ppc_pkg::ppc_word_t rd_word [ppc_pkg::PROP_COUNT];
  modport ctrl (output wr_en, output wr_sel, output wr_data, input rd_word);
  modport store (input wr_en, input wr_sel, input wr_data, output rd_word);
endinterface
`default_nettype wire

/* File: inc/ppc_pkg.sv */
// Purpose: Shared constants and types for the pin property configuration block
// Assumes: 16 pins, one system clock
// Notes: Property codes follow the command encoding
package ppc_pkg;
  localparam int PIN_COUNT = 16;
  typedef logic [15:0] ppc_word_t;
  typedef enum logic [1:0]
  {
    PPC_PROP_HYST = 2'h0,
    PPC_PROP_THRESH = 2'h1,
    PPC_PROP_PULLUP = 2'h2,
    PPC_PROP_DIR = 2'h3
  } ppc_prop_e;
  localparam int PROP_COUNT = 4;
  localparam ppc_word_t RST_HYST = 16'h0000;
  localparam ppc_word_t RST_THRESH = 16'h0000;
  localparam ppc_word_t RST_PULLUP = 16'h0000;
  localparam ppc_word_t RST_DIR = 16'h0000;
  // Sampled input levels: the last two stages of a three-stage synchroniser agree
  localparam int SYNC_STAGES = 3;
endpackage

/* File: logic/ppc_prop_store.sv */
// Purpose: Four 16-bit per-pin property registers
// Assumes: Synchronous active-high reset
// Notes: Only the selected word is written
`timescale 1ns/10ps
`default_nettype none
module ppc_prop_store
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Configuration port
  ppc_cfg_if.store cfg
);
  ppc_pkg::ppc_word_t word [ppc_pkg::PROP_COUNT];
  ppc_pkg::ppc_word_t next_word [ppc_pkg::PROP_COUNT];
  localparam ppc_pkg::ppc_word_t RST_VAL [ppc_pkg::PROP_COUNT] =
    '{ppc_pkg::RST_HYST, ppc_pkg::RST_THRESH, ppc_pkg::RST_PULLUP, ppc_pkg::RST_DIR};

  genvar g;
  generate
    for (g = 0; g < ppc_pkg::PROP_COUNT; g++)
    begin : gen_word
      always_comb
      begin
        next_word[g] = word[g];
        // Whole word replaced, every pin at once
        if (cfg.wr_en && (cfg.wr_sel == 2'(g)))
          next_word[g] = cfg.wr_data;
      end
      always_ff @(posedge clock_i)
      begin
        if (rst_i)
          word[g] <= RST_VAL[g];
        else
          word[g] <= next_word[g];
      end
      assign cfg.rd_word[g] = word[g];
    end
  endgenerate
endmodule
`default_nettype wire

/* File: logic/ppc_top.sv */
// Purpose: Per-pin property configuration for a 16-pin port
// Assumes: Commands and direction writes come from logic on clock_i
// Notes: Pad levels arrive asynchronously and are synchronised here
`timescale 1ns/10ps
`default_nettype none
module ppc_top
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Property command
  input wire logic cmd_valid_i,
  input wire logic [1:0] pin_property_command_i,
  input wire logic [15:0] pin_select_mask_i,
  // Ordinary direction word write
  input wire logic dir_wr_i,
  input wire logic [15:0] port_drive_word_i,
  // Pad comparator results, asynchronous
  input wire logic [15:0] pad_above_ttl_i,
  input wire logic [15:0] pad_above_cmos_i,
  input wire logic [15:0] pad_above_high_i,
  input wire logic [15:0] pad_below_low_i,
  // Configuration state
  output logic [15:0] dir_out_o,
  output logic [15:0] pullup_en_o,
  output logic [15:0] thresh_cmos_o,
  output logic [15:0] hyst_en_o,
  // Interpreted input levels and the zero-mask command flag
  output logic [15:0] pin_level_o,
  output logic [15:0] pin_level_known_o,
  output logic cmd_bad_mask_o
);
  ppc_cfg_if cfg ();

  ppc_prop_store u_store
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .cfg(cfg)
  );

  // Write arbitration; the plain direction write shares the direction word
  always_comb
  begin
    cfg.wr_en = 1'b0;
    cfg.wr_sel = ppc_pkg::PPC_PROP_DIR;
    cfg.wr_data = pin_select_mask_i;
    if (cmd_valid_i)
    begin
      cfg.wr_en = 1'b1;
      cfg.wr_sel = pin_property_command_i;
      cfg.wr_data = pin_select_mask_i;
    end
    else if (dir_wr_i)
    begin
      // Same state as the property command path
      cfg.wr_en = 1'b1;
      cfg.wr_sel = ppc_pkg::PPC_PROP_DIR;
      cfg.wr_data = port_drive_word_i;
    end
  end

  // Three-stage synchronisers per comparator group
  logic [15:0] s_ttl [ppc_pkg::SYNC_STAGES];
  logic [15:0] s_cmos [ppc_pkg::SYNC_STAGES];
  logic [15:0] s_hi [ppc_pkg::SYNC_STAGES];
  logic [15:0] s_lo [ppc_pkg::SYNC_STAGES];
  logic [15:0] f_ttl;
  logic [15:0] f_cmos;
  logic [15:0] f_hi;
  logic [15:0] f_lo;
  logic [15:0] next_f_ttl;
  logic [15:0] next_f_cmos;
  logic [15:0] next_f_hi;
  logic [15:0] next_f_lo;

  always_ff @(posedge clock_i)
  begin
    s_ttl[0] <= pad_above_ttl_i;
    s_cmos[0] <= pad_above_cmos_i;
    s_hi[0] <= pad_above_high_i;
    s_lo[0] <= pad_below_low_i;
    for (int i = 1; i < ppc_pkg::SYNC_STAGES; i++)
    begin
      s_ttl[i] <= s_ttl[i-1];
      s_cmos[i] <= s_cmos[i-1];
      s_hi[i] <= s_hi[i-1];
      s_lo[i] <= s_lo[i-1];
    end
  end

  // A change counts only once stages two and three agree
  always_comb
  begin
    next_f_ttl = f_ttl;
    next_f_cmos = f_cmos;
    next_f_hi = f_hi;
    next_f_lo = f_lo;
    for (int i = 0; i < 16; i++)
    begin
      if (s_ttl[1][i] == s_ttl[2][i])
        next_f_ttl[i] = s_ttl[2][i];
      if (s_cmos[1][i] == s_cmos[2][i])
        next_f_cmos[i] = s_cmos[2][i];
      if (s_hi[1][i] == s_hi[2][i])
        next_f_hi[i] = s_hi[2][i];
      if (s_lo[1][i] == s_lo[2][i])
        next_f_lo[i] = s_lo[2][i];
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      f_ttl <= 16'h0000;
      f_cmos <= 16'h0000;
      f_hi <= 16'h0000;
      f_lo <= 16'h0000;
    end
    else
    begin
      f_ttl <= next_f_ttl;
      f_cmos <= next_f_cmos;
      f_hi <= next_f_hi;
      f_lo <= next_f_lo;
    end
  end

  // Interpretation of each pin
  logic [15:0] hyst_lvl;
  logic [15:0] hyst_known;
  logic [15:0] next_hyst_lvl;
  logic [15:0] next_hyst_known;
  logic [15:0] next_level;
  logic [15:0] next_known;
  logic next_bad;

  always_comb
  begin
    next_hyst_lvl = hyst_lvl;
    next_hyst_known = hyst_known;
    next_level = 16'h0000;
    next_known = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      // Band edges move the latch; inside the band it holds
      if (f_hi[i])
      begin
        next_hyst_lvl[i] = 1'b1;
        next_hyst_known[i] = 1'b1;
      end
      else if (f_lo[i])
      begin
        next_hyst_lvl[i] = 1'b0;
        next_hyst_known[i] = 1'b1;
      end
      // Outputs read nothing back; settings stay but act on inputs only
      if (!cfg.rd_word[ppc_pkg::PPC_PROP_DIR][i])
      begin
        if (cfg.rd_word[ppc_pkg::PPC_PROP_HYST][i])
        begin
          next_level[i] = next_hyst_lvl[i];
          next_known[i] = next_hyst_known[i];
        end
        else
        begin
          next_level[i] = cfg.rd_word[ppc_pkg::PPC_PROP_THRESH][i] ? f_cmos[i]
                                                                  : f_ttl[i];
          next_known[i] = 1'b1;
        end
      end
    end
    // Zero mask is out of contract; flagged but still applied
    next_bad = cmd_valid_i && (pin_select_mask_i == 16'h0000);
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      hyst_lvl <= 16'h0000;
      hyst_known <= 16'h0000;
      pin_level_o <= 16'h0000;
      pin_level_known_o <= 16'h0000;
      cmd_bad_mask_o <= 1'b0;
      dir_out_o <= ppc_pkg::RST_DIR;
      pullup_en_o <= ppc_pkg::RST_PULLUP;
      thresh_cmos_o <= ppc_pkg::RST_THRESH;
      hyst_en_o <= ppc_pkg::RST_HYST;
    end
    else
    begin
      hyst_lvl <= next_hyst_lvl;
      hyst_known <= next_hyst_known;
      pin_level_o <= next_level;
      pin_level_known_o <= next_known;
      cmd_bad_mask_o <= next_bad;
      dir_out_o <= cfg.rd_word[ppc_pkg::PPC_PROP_DIR];
      pullup_en_o <= cfg.rd_word[ppc_pkg::PPC_PROP_PULLUP];
      thresh_cmos_o <= cfg.rd_word[ppc_pkg::PPC_PROP_THRESH];
      hyst_en_o <= cfg.rd_word[ppc_pkg::PPC_PROP_HYST];
    end
  end
endmodule
`default_nettype wire

/* File: tb/pin_property_config_bench.sv */
// Purpose: Self-checking bench for ppc_top
// Assumes: Pads come from the pad model
// Notes: Checks sample 1 ns after an edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) compares++; if ((a) !== (b)) begin err_total++; $display("[FAIL] %0t %h/%h", $time, a, b); end
module pin_property_config_bench;
  logic clock_i = 1'h0, rst_i = 1'h1, cmd_valid_i = 1'h0, dir_wr_i = 1'h0;
  logic [1:0] pin_property_command_i = '0;
  logic [15:0] pin_select_mask_i = '0, port_drive_word_i = '0, hi = '0, mid = '1;
  logic [15:0] pad_above_ttl_i, pad_above_cmos_i, pad_above_high_i, pad_below_low_i;
  logic [15:0] dir_out_o, pullup_en_o, thresh_cmos_o, hyst_en_o, pin_level_o, pin_level_known_o;
  logic cmd_bad_mask_o;
  int err_total = 0, compares = 0;
  ppc_top dut (.*);
  ppc_pad_model pads (.hi_i(hi), .mid_i(mid), .ttl_o(pad_above_ttl_i),
    .cmos_o(pad_above_cmos_i), .top_o(pad_above_high_i), .bot_o(pad_below_low_i));
  always #4 clock_i = ~clock_i;
  task automatic summarize;
    if (err_total == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic cmd(logic [1:0] s, logic [15:0] k);
    @(posedge clock_i);
    cmd_valid_i <= 1'h1;
    pin_property_command_i <= s;
    pin_select_mask_i <= k;
    @(posedge clock_i);
    cmd_valid_i <= 1'h0;
  endtask
  task automatic t_props;
    logic [15:0] w [4] = '{16'h00f0, 16'h000f, 16'h9048, 16'h0113};
    logic f;
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clock_i);
      cmd_valid_i <= 1'h1;
      pin_property_command_i <= s[1:0];
      pin_select_mask_i <= w[s];
    end
    @(posedge clock_i);
    cmd_valid_i <= 1'h0;
    tick(2);
    `CHK({dir_out_o, pullup_en_o, thresh_cmos_o, hyst_en_o}, {w[3], w[2], w[1], w[0]})
    cmd(2'h2, 16'hffff);
    tick(2);
    `CHK({dir_out_o, pullup_en_o, thresh_cmos_o}, {w[3], 16'hffff, w[1]})
    // Zero mask is flagged but still applied
    cmd(2'h2, 16'h0000);
    #1;
    f = cmd_bad_mask_o;
    tick(1);
    `CHK({f, cmd_bad_mask_o, pullup_en_o}, {2'h2, 16'h0000})
  endtask
  task automatic t_shared;
    @(posedge clock_i);
    dir_wr_i <= 1'h1;
    port_drive_word_i <= 16'h8001;
    cmd(2'h3, 16'h00ff);
    dir_wr_i <= 1'h0;
    #1;
    `CHK(dir_out_o, 16'h8001)
    tick(2);
    `CHK(dir_out_o, 16'h00ff)
  endtask
  task automatic t_levels;
    cmd(2'h3, 16'h8000);
    mid <= '1;
    tick(6);
    `CHK({pin_level_o, pin_level_known_o}, {16'h7f00, 16'h7f0f})
    hi <= '1;
    mid <= '0;
    tick(6);
    `CHK(pin_level_o, 16'h7fff)
    hi <= '0;
    mid <= '1;
    tick(6);
    `CHK(pin_level_o, 16'h7ff0)
    mid <= '0;
    tick(6);
    `CHK({pin_level_o, pin_level_known_o}, {16'h0000, 16'h7fff})
  endtask
  initial
  begin
    #40000;
    err_total++;
    summarize;
  end
  initial
  begin
    repeat (2) @(posedge clock_i);
    rst_i <= 1'h0;
    tick(1);
    `CHK({dir_out_o, pullup_en_o, thresh_cmos_o, hyst_en_o}, 64'h0)
    t_props;
    t_shared;
    t_levels;
    summarize;
  end
endmodule
`default_nettype wire

/* File: tb/ppc_pad_model.sv */
// Purpose: Pad comparators for buttons and sources on the port pins
// Assumes: Each pad sits low, mid or high
// Notes: Mid lies above the TTL trip but below half supply
`timescale 1ns/10ps
`default_nettype none
module ppc_pad_model
(
  // Zone selects
  input wire logic [15:0] hi_i,
  input wire logic [15:0] mid_i,
  // Comparator outputs
  output logic [15:0] ttl_o,
  output logic [15:0] cmos_o,
  output logic [15:0] top_o,
  output logic [15:0] bot_o
);
  assign ttl_o = hi_i | mid_i;
  assign cmos_o = hi_i;
  assign top_o = hi_i;
  assign bot_o = ~(hi_i | mid_i);
endmodule
`default_nettype wire

/* File: tb/ppc_top_assertions.sv */
// Purpose: Port checks for ppc_top
// Assumes: Sees top ports only
// Notes: Writes land two sampled edges after the request
`timescale 1ns/10ps
`default_nettype none
module ppc_top_assertions
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Requests
  input wire logic cmd_valid_i,
  input wire logic [1:0] pin_property_command_i,
  input wire logic [15:0] pin_select_mask_i,
  input wire logic dir_wr_i,
  input wire logic [15:0] port_drive_word_i,
  // State
  input wire logic [15:0] dir_out_o,
  input wire logic [15:0] pullup_en_o,
  input wire logic [15:0] thresh_cmos_o,
  input wire logic [15:0] hyst_en_o,
  input wire logic cmd_bad_mask_o
);
  logic [3:0] hit;
  logic [15:0] m;
  assign hit = cmd_valid_i ? 4'h1 << pin_property_command_i : 4'h0;
  assign m = pin_select_mask_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_hyst; hit[0] |-> ##2 hyst_en_o == $past(m, 2); endproperty
  a_hyst: assert property (p_hyst) else $error("hyst word");
  property p_thr; hit[1] |-> ##2 thresh_cmos_o == $past(m, 2); endproperty
  a_thr: assert property (p_thr) else $error("thresh word");
  property p_pul; hit[2] |-> ##2 pullup_en_o == $past(m, 2); endproperty
  a_pul: assert property (p_pul) else $error("pullup word");
  property p_dir; hit[3] |-> ##2 dir_out_o == $past(m, 2); endproperty
  a_dir: assert property (p_dir) else $error("dir word");
  property p_dwr; dir_wr_i && !cmd_valid_i |-> ##2 dir_out_o == $past(port_drive_word_i, 2);
  endproperty
  a_dwr: assert property (p_dwr) else $error("dir write");
  property p_rst; $past(rst_i) |-> {dir_out_o, pullup_en_o, thresh_cmos_o, hyst_en_o} == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  // Reset clears the word too, so a change right after reset is allowed
  property p_keep; $changed(pullup_en_o) |-> $past(hit[2], 2) || $past(rst_i); endproperty
  a_keep: assert property (p_keep) else $error("stray write");
  property p_bad; cmd_valid_i && m == 16'h0 |-> ##[1:2] cmd_bad_mask_o; endproperty
  a_bad: assert property (p_bad) else $error("zero mask flag");
  c_dir: cover property (hit[3]);
  c_both: cover property (dir_wr_i && cmd_valid_i);
  c_bad: cover property (cmd_bad_mask_o);
endmodule
bind ppc_top ppc_top_assertions chk (.*);
`default_nettype wire
